// ---- prs_regs.sv ----
// resolution status view, test register and their avalon slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module prs_regs
    import prs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // transceiver core events and levels
    input  wire logic        dshift_gig,
    input  wire logic        dshift_100,
    input  wire logic        dshift_evt,
    input  wire logic [5:0]  resolved_common_mode_evt,
    input  wire logic [5:0]  resolved_common_mode_nolink,
    input  wire logic        crc_err_evt,
    input  wire logic        rx_fail_evt,
    input  wire logic        false_carrier_evt,
    input  wire logic        tx_err_code_evt,
    // controls to the transceiver core
    output logic             force_link_pass,
    output logic             mdi_swap,
    output logic             an_restart,
    output logic             preamble_optional,
    // interrupt
    output logic             irq
);

    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
        $error("CNT_W must lie between 2 and 16");
    end

    logic        wait_q;
    logic [31:0] rdata_q;
    logic        sel_q;
    logic        nogig_q;
    logic        no100_q;
    logic [12:0] stat_q;
    logic [12:0] stat_d;
    logic [15:0] test_q;
    logic        an_dis_q;
    logic        an_rst_q;
    logic [CNT_W-1:0] rxf_q;
    logic [CNT_W-1:0] fcar_q;
    logic        crc_sel_q;
    logic [2:0]  irq_st_q;
    logic [2:0]  irq_msk_q;
    logic        irq_q;
    logic        pre_q;

    // bus decode
    wire [7:0]  idx       = avs_address[9:2];
    wire        take_wr   = avs_write & ~wait_q;
    wire        take_rd   = avs_read & ~wait_q;
    wire        hit_sh    = idx == IDX_SHARED;
    wire        hit_test  = idx == IDX_TEST;
    wire        hit_ctrl  = idx == IDX_CTRL;
    wire        hit_ist   = idx == IDX_IRQ_ST;
    wire        hit_imsk  = idx == IDX_IRQ_MSK;
    wire        hit_rxf   = idx == IDX_RXFAIL;
    wire        hit_fcar  = idx == IDX_FCAR;
    wire [15:0] lane_m    = {{8{avs_byteenable[1]}},
                             {8{avs_byteenable[0]}}};
    wire [15:0] wdat      = avs_writedata[15:0];
    wire        wr_sh     = take_wr & hit_sh & avs_byteenable[1];
    wire        wr_ctrl   = take_wr & hit_ctrl & avs_byteenable[1];

    // status view contents
    wire [15:0] sh_view   = {sel_q, nogig_q, no100_q, stat_q};
    // normal view: the seed register lives elsewhere, only the selector
    wire [15:0] sh_norm   = {sel_q, 15'h0000};
    wire [15:0] sh_rd     = sel_q ? sh_view : sh_norm; // R1

    // ctrl word mirrors the autoneg disable bit; restart always reads zero
    wire [15:0] ctrl_rd   = {3'h0, an_dis_q, 12'h000};

    wire [15:0] rd_mux16 =
        hit_sh   ? sh_rd :
        hit_test ? test_q :
        hit_ctrl ? ctrl_rd :
        hit_rxf  ? 16'(rxf_q) :
        hit_fcar ? 16'(fcar_q) :
        hit_ist  ? {13'h0000, irq_st_q} :
        hit_imsk ? {13'h0000, irq_msk_q} :
        16'h0000;

    // read clear only drops bits already shown, so an event landing
    // between capture and acceptance survives for the next read
    wire        rd_clr    = take_rd & hit_sh & sel_q;
    wire [12:0] clr_mask  = rd_clr ? rdata_q[12:0] : 13'h0000;
    wire [12:0] set_vec   = {dshift_evt, resolved_common_mode_evt,
                             resolved_common_mode_nolink};
    wire        an_clr    = an_dis_q | an_rst_q;

    always_comb begin
        if (an_clr) begin
            stat_d = 13'h0000; // R7
        end else begin
            stat_d = (stat_q & ~clr_mask) | set_vec; // R4 R5 R6 R16
        end
    end

    // one wait cycle: capture on the first edge, answer on the next
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= ~((avs_read | avs_write) & wait_q);
            if (avs_read & wait_q) begin
                rdata_q <= {16'h0000, rd_mux16};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_q  <= 1'b0; // R15
            stat_q <= 13'h0000;
        end else begin
            stat_q <= stat_d;
            if (wr_sh) begin
                sel_q <= wdat[SH_SEL]; // R1
            end
        end
    end

    // downshift suppression levels from the core
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nogig_q <= 1'b0;
            no100_q <= 1'b0;
        end else begin
            nogig_q <= dshift_gig; // R2
            no100_q <= dshift_100; // R3
        end
    end

    // reserved bits never store, so stray host data cannot leak back
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            test_q <= RST_REG16; // R15
        end else if (take_wr & hit_test) begin
            test_q <= (test_q & ~(lane_m & TST_WMASK))
                    | (wdat & lane_m & TST_WMASK); // R13
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            an_dis_q <= 1'b0;
            an_rst_q <= 1'b0;
        end else begin
            an_rst_q <= wr_ctrl & wdat[CTRL_AN_RST];
            if (wr_ctrl) begin
                an_dis_q <= wdat[CTRL_AN_DIS];
            end
        end
    end

    // counters saturate rather than wrap
    wire rxf_inc = test_q[TST_CRC] ? crc_err_evt : rx_fail_evt; // R8
    wire fc_inc  = test_q[TST_TXERR] ? tx_err_code_evt
                                     : false_carrier_evt; // R9
    wire crc_on  = test_q[TST_CRC] & ~crc_sel_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxf_q     <= '0;
            fcar_q    <= '0;
            crc_sel_q <= 1'b0;
        end else begin
            crc_sel_q <= test_q[TST_CRC];
            if (crc_on) begin
                rxf_q <= '0; // R8
            end else if (rxf_inc && rxf_q != '1) begin
                rxf_q <= rxf_q + 1'b1;
            end
            if (fc_inc && fcar_q != '1) begin
                fcar_q <= fcar_q + 1'b1;
            end
        end
    end

    // interrupt: sticky, write one to clear, event wins over clear
    wire [2:0] irq_ev;
    assign irq_ev[IRQ_DNSHIFT]  = dshift_evt;
    assign irq_ev[IRQ_RESOLVED] = |resolved_common_mode_evt;
    assign irq_ev[IRQ_NOLINK]   = |resolved_common_mode_nolink;
    wire       ist_wr  = take_wr & hit_ist & avs_byteenable[0];
    wire [2:0] ist_clr = ist_wr ? wdat[IRQ_N-1:0] : 3'h0;
    wire [2:0] ist_d   = (irq_st_q & ~ist_clr) | irq_ev;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_st_q  <= RST_IRQ;
            irq_msk_q <= RST_IRQ;
            irq_q     <= 1'b0;
        end else begin
            irq_st_q <= ist_d;
            irq_q    <= |(ist_d & irq_msk_q);
            if (take_wr & hit_imsk & avs_byteenable[0]) begin
                irq_msk_q <= wdat[IRQ_N-1:0];
            end
        end
    end

    // once a first access arrives, later ones may drop the preamble;
    // there is deliberately no way to turn this back off
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q <= 1'b0;
        end else if (take_rd | take_wr) begin
            pre_q <= 1'b1; // R14
        end
    end

    assign avs_readdata      = rdata_q;
    assign avs_waitrequest   = wait_q;
    assign force_link_pass   = test_q[TST_FLINK]; // R10
    assign mdi_swap          = test_q[TST_MDI]; // R11
    assign an_restart        = an_rst_q;
    assign preamble_optional = pre_q;
    assign irq               = irq_q;

    // checks
    property p_sel_read;
        @(posedge clk_sys) disable iff (rst)
        (avs_read && wait_q && hit_sh) |=> (rdata_q[15] == sel_q);
    endproperty
    a_sel_read: assert property (p_sel_read) // R1
        else $error("selector readback wrong");

    property p_nogig;
        @(posedge clk_sys) disable iff (rst)
        dshift_gig |=> nogig_q;
    endproperty
    a_nogig: assert property (p_nogig) // R2
        else $error("gigabit suppression not shown");

    property p_no100;
        @(posedge clk_sys) disable iff (rst)
        !dshift_100 |=> !no100_q;
    endproperty
    a_no100: assert property (p_no100) // R3
        else $error("100TX suppression shown wrongly");

    property p_dnshift;
        @(posedge clk_sys) disable iff (rst)
        (dshift_evt && !an_clr) |=> stat_q[12];
    endproperty
    a_dnshift: assert property (p_dnshift) // R4
        else $error("downshift not latched");

    property p_resolved;
        @(posedge clk_sys) disable iff (rst)
        (resolved_common_mode_evt != 6'h00 && !an_clr) |=>
            ((stat_q[11:6] & $past(resolved_common_mode_evt))
             == $past(resolved_common_mode_evt));
    endproperty
    a_resolved: assert property (p_resolved) // R5
        else $error("resolved mode not latched");

    property p_nolink;
        @(posedge clk_sys) disable iff (rst)
        (resolved_common_mode_nolink != 6'h00 && !an_clr) |=>
            ((stat_q[5:0] & $past(resolved_common_mode_nolink))
             == $past(resolved_common_mode_nolink));
    endproperty
    a_nolink: assert property (p_nolink) // R6
        else $error("no-link mode not latched");

    property p_an_clear;
        @(posedge clk_sys) disable iff (rst)
        an_clr |=> (stat_q == 13'h0000);
    endproperty
    a_an_clear: assert property (p_an_clear) // R7
        else $error("autoneg clear missed");

    property p_crc_start;
        @(posedge clk_sys) disable iff (rst)
        $rose(test_q[TST_CRC]) |=> (rxf_q == '0);
    endproperty
    a_crc_start: assert property (p_crc_start) // R8
        else $error("crc counter did not restart");

    property p_fcar;
        @(posedge clk_sys) disable iff (rst)
        (test_q[TST_TXERR] && tx_err_code_evt && fcar_q != '1)
            |=> (fcar_q == $past(fcar_q) + 1'b1);
    endproperty
    a_fcar: assert property (p_fcar) // R9
        else $error("error code count missed");

    property p_flink;
        @(posedge clk_sys) disable iff (rst)
        (take_wr && hit_test && avs_byteenable[1]) |=>
            (force_link_pass == $past(wdat[TST_FLINK]));
    endproperty
    a_flink: assert property (p_flink) // R10
        else $error("force link not applied");

    property p_mdi;
        @(posedge clk_sys) disable iff (rst)
        (take_wr && hit_test && avs_byteenable[0]) |=>
            (mdi_swap == $past(wdat[TST_MDI]));
    endproperty
    a_mdi: assert property (p_mdi) // R11
        else $error("mdi swap not applied");

    property p_resv;
        @(posedge clk_sys) disable iff (rst)
        (test_q & ~TST_WMASK) == 16'h0000;
    endproperty
    a_resv: assert property (p_resv) // R13
        else $error("reserved test bit stored");

    property p_preamble;
        @(posedge clk_sys) disable iff (rst)
        pre_q |=> pre_q;
    endproperty
    a_preamble: assert property (p_preamble) // R14
        else $error("preamble suppression turned off");

    property p_set_wins;
        @(posedge clk_sys) disable iff (rst)
        (rd_clr && dshift_evt && !an_clr) |=> stat_q[12];
    endproperty
    a_set_wins: assert property (p_set_wins) // R16
        else $error("event lost to read clear");

    property p_answer;
        @(posedge clk_sys) disable iff (rst)
        ((avs_read || avs_write) && wait_q) |=> !wait_q ##1 wait_q;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer timing wrong");

    c_read_status: cover property (@(posedge clk_sys) disable iff (rst)
        rd_clr && rdata_q[12:0] != 13'h0000);
    c_set_clear: cover property (@(posedge clk_sys) disable iff (rst)
        rd_clr && dshift_evt);
    c_irq: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(irq_q));
endmodule

// ---- prs_pkg.sv ----
// constants for the resolution status and test register pair
//
// Behaviour
// R1: bit 15 selects the status view
// R2: bit 14 shows gigabit advertising suppressed
// R3: bit 13 shows 100TX advertising suppressed
// R4: bit 12 latches downshift, cleared by read
// R5: bits 11..6 latch resolved mode, read-clear
// R6: bits 5..0 latch resolved mode, no link
// R7: autoneg disable or restart clears bits 12..0
// R8: test bit 15 makes 14h a CRC counter
// R9: test bit 14 makes 13h count error codes
// R10: test bit 12 forces link pass state
// R11: test bit 7 swaps MDI pairs manually
// R12: host: nonlink, set swap, then force 100TX
// R13: host writes zero to reserved test bits
// R14: preamble on first frame, then optional always
// R15: both registers read zero after reset
// R16: an event beats a same-cycle read clear
package prs_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CTRL    = 8'h00;
    localparam logic [7:0] IDX_FCAR    = 8'h13;
    localparam logic [7:0] IDX_RXFAIL  = 8'h14;
    localparam logic [7:0] IDX_IRQ_ST  = 8'h30;
    localparam logic [7:0] IDX_IRQ_MSK = 8'h31;
    localparam logic [7:0] IDX_SHARED  = 8'h3a;
    localparam logic [7:0] IDX_TEST    = 8'h3c;
    // field positions
    localparam int SH_SEL      = 15;
    localparam int SH_NOGIG    = 14;
    localparam int SH_NO100    = 13;
    localparam int SH_DNSHIFT  = 12;
    localparam int SH_RESOLVED_LO = 6;
    localparam int TST_CRC     = 15;
    localparam int TST_TXERR   = 14;
    localparam int TST_FLINK   = 12;
    localparam int TST_MDI     = 7;
    localparam int CTRL_AN_DIS = 12;
    localparam int CTRL_AN_RST = 9;
    localparam int IRQ_DNSHIFT = 0;
    localparam int IRQ_RESOLVED = 1;
    localparam int IRQ_NOLINK  = 2;
    localparam int IRQ_N       = 3;
    // writable test bits; reserved bits store nothing and read zero
    localparam logic [15:0] TST_WMASK = 16'hd080;
    // reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [2:0]  RST_IRQ   = 3'h0;
endpackage

// ---- tb_phy_resolution_status_test_regs.sv ----
// self-checking testbench for the resolution status and test registers
`timescale 1ns/1ps
module tb_phy_resolution_status_test_regs;
    import prs_pkg::*;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
$display("Error at %0t: got %h expected %h", $time, a, b); end end

    logic        clk_sys        = 1'h0;
    logic        rst            = 1'h1;
    logic [9:0]  avs_address    = 10'h0;
    logic        avs_read       = 1'h0;
    logic        avs_write      = 1'h0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        dshift_gig     = 1'h0;
    logic        dshift_100     = 1'h0;
    // {crc, rx fail, false carrier, tx code, downshift, mode[5:0], nolink[5:0]}
    logic [16:0] pl_q           = 17'h0;
    logic        force_link_pass;
    logic        mdi_swap;
    logic        an_restart;
    logic        preamble_optional;
    logic        irq;
    logic [31:0] rd;
    logic [15:0] x;
    int          bad_count      = 0;
    int          checks         = 0;
    int          restarts       = 0;

    prs_regs dut (
        .clk_sys             (clk_sys),
        .rst                 (rst),
        .avs_address         (avs_address),
        .avs_read            (avs_read),
        .avs_write           (avs_write),
        .avs_writedata       (avs_writedata),
        .avs_byteenable      (avs_byteenable),
        .avs_readdata        (avs_readdata),
        .avs_waitrequest     (avs_waitrequest),
        .dshift_gig          (dshift_gig),
        .dshift_100          (dshift_100),
        .dshift_evt          (pl_q[12]),
        .resolved_common_mode_evt    (pl_q[11:6]),
        .resolved_common_mode_nolink (pl_q[5:0]),
        .crc_err_evt         (pl_q[16]),
        .rx_fail_evt         (pl_q[15]),
        .false_carrier_evt   (pl_q[14]),
        .tx_err_code_evt     (pl_q[13]),
        .force_link_pass     (force_link_pass),
        .mdi_swap            (mdi_swap),
        .an_restart          (an_restart),
        .preamble_optional   (preamble_optional),
        .irq                 (irq)
    );

    always #5 clk_sys = ~clk_sys;

    // counted away from the rising edge so the pulse is seen exactly once
    always @(negedge clk_sys) begin
        if (an_restart === 1'h1) begin
            restarts++;
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one avalon transfer; the request stands until the rising edge at
    // which waitrequest is seen low, and read data is taken at that edge
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [15:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address    <= {idx, 2'h0};
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_writedata  <= {16'h0, wd};
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        if (avs_waitrequest !== 1'h0) begin
            bad_count++;
            $display("Error at %0t: bus timeout", $time);
            finish_test();
        end
        rd = avs_readdata;
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        bus(1'h1, idx, wd, 4'h3);
    endtask

    task automatic rc(input logic [7:0] idx, input logic [15:0] exp);
        bus(1'h0, idx, 16'h0, 4'h3);
        `CHK(rd, {16'h0, exp})
    endtask

    // n single-cycle pulses on the core event inputs
    task automatic pulse(input logic [16:0] v, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            pl_q <= v;
            @(posedge clk_sys);
            pl_q <= 17'h0;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        `CHK(preamble_optional, 1'h0)
        rc(IDX_SHARED, 16'h0);
        rc(IDX_TEST, 16'h0);
        `CHK(preamble_optional, 1'h1)
        `CHK({force_link_pass, mdi_swap}, 2'h0)
        $display("test reset done");

        wr(IDX_SHARED, 16'hffff);
        rc(IDX_SHARED, 16'h8000);
        dshift_gig <= 1'h1;
        rc(IDX_SHARED, 16'hc000);
        dshift_gig <= 1'h0;
        dshift_100 <= 1'h1;
        rc(IDX_SHARED, 16'ha000);
        dshift_100 <= 1'h0;
        wr(8'h3b, 16'hffff);
        rc(8'h3b, 16'h0);
        $display("test view select done");

        // masked event must not reach the interrupt line
        pulse(17'h1000, 1);
        repeat (2) @(negedge clk_sys);
        `CHK(irq, 1'h0)
        rc(IDX_IRQ_ST, 16'h1);
        wr(IDX_IRQ_MSK, 16'h7);
        repeat (2) @(negedge clk_sys);
        `CHK(irq, 1'h1)
        wr(IDX_IRQ_ST, 16'h1);
        rc(IDX_SHARED, 16'h9000);
        for (int i = 0; i < 13; i++) begin
            pulse(17'h1 << i, 1);
            rc(IDX_SHARED, 16'h8000 | (16'h1 << i));
            rc(IDX_SHARED, 16'h8000);
            x = (i == 12) ? 16'h1 : (i >= 6) ? 16'h2 : 16'h4;
            `CHK(irq, 1'h1)
            rc(IDX_IRQ_ST, x);
            wr(IDX_IRQ_ST, x);
            repeat (2) @(negedge clk_sys);
            `CHK(irq, 1'h0)
        end
        // a repeat of the event lands on the clearing edge of the read
        pulse(17'h1800, 1);
        fork
            rc(IDX_SHARED, 16'h9800);
            begin
                repeat (2) @(posedge clk_sys);
                pl_q <= 17'h1800;
                @(posedge clk_sys);
                pl_q <= 17'h0;
            end
        join
        rc(IDX_SHARED, 16'h9800);
        rc(IDX_SHARED, 16'h8000);
        $display("test latched status done");

        pulse(17'h0020, 1);
        wr(IDX_CTRL, 16'h1000);
        rc(IDX_SHARED, 16'h8000);
        pulse(17'h0020, 1);
        rc(IDX_SHARED, 16'h8000);
        wr(IDX_CTRL, 16'h0);
        pulse(17'h0020, 1);
        wr(IDX_CTRL, 16'h0200);
        rc(IDX_SHARED, 16'h8000);
        `CHK(restarts, 1)
        wr(IDX_SHARED, 16'h0);
        rc(IDX_SHARED, 16'h0);
        $display("test autoneg clear done");

        pulse(17'h08000, 3);
        pulse(17'h04000, 2);
        pulse(17'h12000, 2);
        rc(IDX_RXFAIL, 16'h3);
        rc(IDX_FCAR, 16'h2);
        wr(IDX_TEST, 16'h0080);
        wr(IDX_TEST, 16'hd080);
        rc(IDX_TEST, 16'hd080);
        `CHK({force_link_pass, mdi_swap}, 2'h3)
        pulse(17'h1c000, 2);
        pulse(17'h02000, 1);
        rc(IDX_RXFAIL, 16'h2);
        rc(IDX_FCAR, 16'h3);
        $display("test counters done");

        // only the low lane is written, so the high bits survive
        bus(1'h1, IDX_TEST, 16'h0, 4'h1);
        rc(IDX_TEST, 16'hd000);
        `CHK({force_link_pass, mdi_swap}, 2'h2)
        wr(IDX_TEST, 16'h0);
        rc(IDX_TEST, 16'h0);
        `CHK(force_link_pass, 1'h0)
        `CHK(preamble_optional, 1'h1)
        $display("test control bits done");
        finish_test();
    end
endmodule
